//--- src/pbbl_pkg.sv
package pbbl_pkg;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned PIN_W      = 16;
  localparam int unsigned FIFO_DEPTH = 4;

  // stream keys for 8-bit and 16-bit memory width
  localparam logic [WORD_W-1:0] KEY_8BIT  = 16'h08AA;
  localparam logic [WORD_W-1:0] KEY_16BIT = 16'h10AA;
  localparam logic [WORD_W-1:0] SIZE_END  = 16'h0000;
  localparam logic [WORD_W-1:0] CNT_ONE   = 16'h0001;

  localparam logic [3:0] RSVD_LAST = 4'h7;
  localparam logic [3:0] RSVD_ZERO = 4'h0;
  localparam logic [3:0] RSVD_STEP = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0001;

  // handshake output idles high: not ready
  localparam logic DEV_HS_RST = 1'h1;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } pbbl_ram_wr_s;

  localparam pbbl_ram_wr_s RAM_WR_RST = '{we: 1'h0, addr: 32'h0000_0000, data: 16'h0000};

  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_READY = 2'h1,
    HS_ACK   = 2'h3
  } pbbl_hs_e;

  typedef enum logic [3:0] {
    P_KEY     = 4'h0,
    P_RSVD    = 4'h1,
    P_EP_HI   = 4'h3,
    P_EP_LO   = 4'h2,
    P_SIZE    = 4'h6,
    P_ADDR_HI = 4'h7,
    P_ADDR_LO = 4'h5,
    P_DATA    = 4'h4,
    P_DONE    = 4'hC,
    P_ABORT   = 4'h8
  } pbbl_parse_e;

endpackage

//--- src/pbbl_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module pbbl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != CNT_FULL);
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_ONE;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_ONE;
    end
    if (push && !pop)
    begin
      next_count = count + CNT_ONE;
    end
    else if (pop && !push)
    begin
      next_count = count - CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage needs no reset; count guards reads
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

//--- src/pbbl_loader.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - The device asks for the next byte by driving its handshake output low.
// - On the host's low level the device captures the data and then drives its handshake high.
// - The host returns its handshake high and only then may the device go low again.
// - The four-phase exchange repeats for every byte with no timeout on either side.
// - Only the lower eight data lines are used and any upper byte is ignored.
// - Two bytes make one word, first byte low, and the entry point comes upper word first.
// - Either key value is accepted, and any other first word aborts toward the flash path.
// - After the key eight reserved words are discarded, then two entry-point words are read.
// - Every block starts with a 16-bit word count.
// - The count is followed by a 32-bit address, upper word first, and that many data words.
// - Block data goes into on-chip RAM at consecutive addresses from the destination.
// - A block count of zero ends the stream and the entry point is handed back.
module pbbl_loader (
  input  wire logic                         sys_clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic [pbbl_pkg::PIN_W-1:0]   par_data_i,
  input  wire logic                         host_handshake_i,
  output logic                              dev_handshake_o,
  output pbbl_pkg::pbbl_ram_wr_s            ram_wr_o,
  output logic [pbbl_pkg::ADDR_W-1:0]       entry_point_o,
  output logic                              load_done_o,
  output logic                              load_abort_o
);

  function automatic logic key_ok(input logic [pbbl_pkg::WORD_W-1:0] w);
    key_ok = (w == pbbl_pkg::KEY_8BIT) || (w == pbbl_pkg::KEY_16BIT);
  endfunction

  logic [pbbl_pkg::BYTE_W-1:0] data_meta;
  logic [pbbl_pkg::BYTE_W-1:0] data_sync;
  logic                        hs_meta;
  logic                        hs_sync;

  always_ff @(posedge sys_clk_i)
  begin
    data_meta <= par_data_i[pbbl_pkg::BYTE_W-1:0];
    data_sync <= data_meta;
    hs_meta   <= host_handshake_i;
    hs_sync   <= hs_meta;
  end

  // handshake engine
  pbbl_pkg::pbbl_hs_e          hs_state;
  pbbl_pkg::pbbl_hs_e          next_hs_state;
  logic                        next_dev_hs;
  logic                        fifo_in_ready;
  logic                        fifo_push;

  // ready is offered only with room, so a captured byte is never lost
  always_comb
  begin
    next_hs_state = hs_state;
    next_dev_hs   = dev_handshake_o;
    fifo_push     = 1'b0;
    case (hs_state)
      pbbl_pkg::HS_IDLE:
      begin
        if (hs_sync && fifo_in_ready)
        begin
          next_dev_hs   = 1'b0;
          next_hs_state = pbbl_pkg::HS_READY;
        end
      end
      pbbl_pkg::HS_READY:
      begin
        if (!hs_sync)
        begin
          fifo_push     = 1'b1;
          next_dev_hs   = 1'b1;
          next_hs_state = pbbl_pkg::HS_ACK;
        end
      end
      pbbl_pkg::HS_ACK:
      begin
        if (hs_sync)
        begin
          next_hs_state = pbbl_pkg::HS_IDLE;
        end
      end
      default:
      begin
        next_dev_hs   = pbbl_pkg::DEV_HS_RST;
        next_hs_state = pbbl_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      hs_state        <= pbbl_pkg::HS_IDLE;
      dev_handshake_o <= pbbl_pkg::DEV_HS_RST;
    end
    else
    begin
      hs_state        <= next_hs_state;
      dev_handshake_o <= next_dev_hs;
    end
  end

  // byte buffer between pins and parser
  logic                        fifo_out_valid;
  logic                        fifo_out_ready;
  logic [pbbl_pkg::BYTE_W-1:0] fifo_byte;

  pbbl_fifo #(
    .WIDTH (pbbl_pkg::BYTE_W),
    .DEPTH (pbbl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (fifo_push),
    .in_data_i   (data_sync),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_byte),
    .out_ready_i (fifo_out_ready)
  );

  // stream parser
  pbbl_pkg::pbbl_parse_e        pstate;
  pbbl_pkg::pbbl_parse_e        next_pstate;
  logic [pbbl_pkg::BYTE_W-1:0]  byte_lo;
  logic [pbbl_pkg::BYTE_W-1:0]  next_byte_lo;
  logic                         half;
  logic                         next_half;
  logic [3:0]                   rsvd_cnt;
  logic [3:0]                   next_rsvd_cnt;
  logic [pbbl_pkg::WORD_W-1:0]  blk_cnt;
  logic [pbbl_pkg::WORD_W-1:0]  next_blk_cnt;
  logic [pbbl_pkg::ADDR_W-1:0]  dst;
  logic [pbbl_pkg::ADDR_W-1:0]  next_dst;
  logic [pbbl_pkg::ADDR_W-1:0]  next_entry;
  pbbl_pkg::pbbl_ram_wr_s       next_ram_wr;
  logic                         next_done;
  logic                         next_abort;
  logic                         pop;
  logic                         word_v;
  logic [pbbl_pkg::WORD_W-1:0]  word;

  // once finished the buffer fills and the pins stall the host
  assign fifo_out_ready = (pstate != pbbl_pkg::P_DONE) && (pstate != pbbl_pkg::P_ABORT);
  assign pop            = fifo_out_valid && fifo_out_ready;
  assign word           = {fifo_byte, byte_lo};
  assign word_v         = pop && half;

  always_comb
  begin
    next_pstate   = pstate;
    next_byte_lo  = byte_lo;
    next_half     = half;
    next_rsvd_cnt = rsvd_cnt;
    next_blk_cnt  = blk_cnt;
    next_dst      = dst;
    next_entry    = entry_point_o;
    next_ram_wr   = ram_wr_o;
    next_ram_wr.we = 1'b0;
    next_done     = 1'b0;
    next_abort    = load_abort_o;
    if (pop)
    begin
      next_half = !half;
      if (!half)
      begin
        next_byte_lo = fifo_byte;
      end
    end
    if (word_v)
    begin
      case (pstate)
        pbbl_pkg::P_KEY:
        begin
          if (key_ok(word))
          begin
            next_rsvd_cnt = pbbl_pkg::RSVD_ZERO;
            next_pstate   = pbbl_pkg::P_RSVD;
          end
          else
          begin
            next_abort  = 1'b1;
            next_pstate = pbbl_pkg::P_ABORT;
          end
        end
        pbbl_pkg::P_RSVD:
        begin
          if (rsvd_cnt == pbbl_pkg::RSVD_LAST)
          begin
            next_pstate = pbbl_pkg::P_EP_HI;
          end
          else
          begin
            next_rsvd_cnt = rsvd_cnt + pbbl_pkg::RSVD_STEP;
          end
        end
        pbbl_pkg::P_EP_HI:
        begin
          next_entry[pbbl_pkg::ADDR_W-1:pbbl_pkg::WORD_W] = word;
          next_pstate = pbbl_pkg::P_EP_LO;
        end
        pbbl_pkg::P_EP_LO:
        begin
          next_entry[pbbl_pkg::WORD_W-1:0] = word;
          next_pstate = pbbl_pkg::P_SIZE;
        end
        pbbl_pkg::P_SIZE:
        begin
          if (word == pbbl_pkg::SIZE_END)
          begin
            next_done   = 1'b1;
            next_pstate = pbbl_pkg::P_DONE;
          end
          else
          begin
            next_blk_cnt = word;
            next_pstate  = pbbl_pkg::P_ADDR_HI;
          end
        end
        pbbl_pkg::P_ADDR_HI:
        begin
          next_dst[pbbl_pkg::ADDR_W-1:pbbl_pkg::WORD_W] = word;
          next_pstate = pbbl_pkg::P_ADDR_LO;
        end
        pbbl_pkg::P_ADDR_LO:
        begin
          next_dst[pbbl_pkg::WORD_W-1:0] = word;
          next_pstate = pbbl_pkg::P_DATA;
        end
        pbbl_pkg::P_DATA:
        begin
          next_ram_wr.we   = 1'b1;
          next_ram_wr.addr = dst;
          next_ram_wr.data = word;
          next_dst         = dst + pbbl_pkg::ADDR_STEP;
          next_blk_cnt     = blk_cnt - pbbl_pkg::CNT_ONE;
          if (blk_cnt == pbbl_pkg::CNT_ONE)
          begin
            next_pstate = pbbl_pkg::P_SIZE;
          end
        end
        default:
        begin
          next_pstate = pstate;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      pstate        <= pbbl_pkg::P_KEY;
      byte_lo       <= '0;
      half          <= 1'b0;
      rsvd_cnt      <= pbbl_pkg::RSVD_ZERO;
      blk_cnt       <= '0;
      dst           <= '0;
      entry_point_o <= '0;
      ram_wr_o      <= pbbl_pkg::RAM_WR_RST;
      load_done_o   <= 1'b0;
      load_abort_o  <= 1'b0;
    end
    else
    begin
      pstate        <= next_pstate;
      byte_lo       <= next_byte_lo;
      half          <= next_half;
      rsvd_cnt      <= next_rsvd_cnt;
      blk_cnt       <= next_blk_cnt;
      dst           <= next_dst;
      entry_point_o <= next_entry;
      ram_wr_o      <= next_ram_wr;
      load_done_o   <= next_done;
      load_abort_o  <= next_abort;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_LOW_NEEDS_HOST_HIGH: assert property (
    $fell(dev_handshake_o) |-> $past(hs_sync) && $past(hs_state) == pbbl_pkg::HS_IDLE)
    else $error("handshake went low while host still low");
  AST_CAPTURE_RAISES: assert property (
    (hs_state == pbbl_pkg::HS_READY && !hs_sync) |=> dev_handshake_o && fifo_push == 1'b0)
    else $error("device did not report read complete");
  AST_READY_HOLDS_LOW: assert property (
    (hs_state == pbbl_pkg::HS_READY && hs_sync) |=> !dev_handshake_o)
    else $error("ready dropped before host data");
  AST_KEY_ABORT: assert property (
    (pstate == pbbl_pkg::P_KEY && word_v && !key_ok(word)) |=> load_abort_o ##1 load_abort_o)
    else $error("bad key did not abort");
  AST_RSVD_EIGHT: assert property (
    (pstate == pbbl_pkg::P_RSVD && word_v && rsvd_cnt == pbbl_pkg::RSVD_LAST)
      |=> pstate == pbbl_pkg::P_EP_HI)
    else $error("reserved word count wrong");
  AST_DATA_WRITE: assert property (
    (pstate == pbbl_pkg::P_DATA && word_v)
      |=> ram_wr_o.we && ram_wr_o.data == $past(word) && ram_wr_o.addr == $past(dst))
    else $error("data word not written at destination");
  AST_ZERO_SIZE_DONE: assert property (
    (pstate == pbbl_pkg::P_SIZE && word_v && word == pbbl_pkg::SIZE_END)
      |=> load_done_o ##1 !load_done_o)
    else $error("zero size did not finish");
  AST_DONE_ENTRY: assert property (
    load_done_o |-> $stable(entry_point_o) && !load_abort_o)
    else $error("entry point moved at done");

endmodule

`default_nettype wire

//--- dv/pbbl_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module pbbl_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic        dev_handshake_i,
  output var  logic [15:0] par_data_o,
  output var  logic        host_handshake_o
);
  logic [15:0] q[$];
  logic        busy;
  int          gap;

  initial
  begin
    par_data_o = 16'hFFFF;
    host_handshake_o = 1'b1;
    busy = 1'b0;
    gap = 1;
    forever
    begin
      @(negedge sys_clk_i);
      if (q.size() != 0 && dev_handshake_i === 1'b0)
      begin
        busy = 1'b1;
        par_data_o = q.pop_front();
        repeat (gap) @(negedge sys_clk_i);
        host_handshake_o = 1'b0;
        while (dev_handshake_i !== 1'b1) @(negedge sys_clk_i);
        host_handshake_o = 1'b1;
        // pulled-up lines read high once released
        par_data_o = 16'hFFFF;
        busy = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

//--- dv/pbbl_loader_test.sv
`timescale 1ns/1ns
`default_nettype none

module pbbl_loader_test;
  logic                   sys_clk;
  logic                   sys_rst;
  logic [15:0]            par_data;
  logic                   host_hs;
  logic                   dev_hs;
  pbbl_pkg::pbbl_ram_wr_s ram_wr;
  logic [31:0]            entry_point;
  logic                   load_done;
  logic                   load_abort;
  int                     mismatches;
  int                     checks_done;
  int                     cycles;
  int                     done_len;
  logic [47:0]            wr_log[$];

  pbbl_loader dut (
    .sys_clk_i        (sys_clk),
    .sys_rst_i        (sys_rst),
    .par_data_i       (par_data),
    .host_handshake_i (host_hs),
    .dev_handshake_o  (dev_hs),
    .ram_wr_o         (ram_wr),
    .entry_point_o    (entry_point),
    .load_done_o      (load_done),
    .load_abort_o     (load_abort)
  );

  pbbl_host_model host (
    .sys_clk_i        (sys_clk),
    .dev_handshake_i  (dev_hs),
    .par_data_o       (par_data),
    .host_handshake_o (host_hs)
  );

  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (ram_wr.we === 1'b1) wr_log.push_back({ram_wr.addr, ram_wr.data});
    if (load_done === 1'b1) done_len = done_len + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, msg, got, exp);
    end
  endtask

  task automatic do_reset();
    host.q.delete();
    sys_rst = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(dev_hs, 1, "handshake in reset");
    chk(ram_wr, 0, "ram port in reset");
    chk({entry_point, load_done, load_abort}, 0, "results in reset");
    wr_log.delete();
    done_len = 0;
    sys_rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(dev_hs, 0, "ready after reset");
  endtask

  // low byte first; junk on the upper lines
  task automatic put_word(input logic [15:0] w, input logic [7:0] junk);
    host.q.push_back({junk, w[7:0]});
    host.q.push_back({junk, w[15:8]});
  endtask

  task automatic drain();
    while (host.q.size() != 0 || host.busy) @(negedge sys_clk);
    // fifo and parser flush
    repeat (12) @(negedge sys_clk);
  endtask

  task automatic t_stream(input logic [15:0] key, input int gap);
    logic [47:0] exp[5];
    host.gap = gap;
    do_reset();
    put_word(key, 8'h00);
    for (int i = 0; i < 8; i++) put_word(16'hA5A5 ^ i[15:0], 8'hC3);
    put_word(16'h00BB, 8'h5A);
    put_word(16'hCCDD, 8'h5A);
    // two blocks, second crosses a 64K boundary
    put_word(16'h0003, 8'h77);
    put_word(16'h0001, 8'h77);
    put_word(16'h2340, 8'h77);
    for (int i = 0; i < 3; i++) put_word(16'hF00D + i[15:0], 8'h77);
    put_word(16'h0002, 8'h77);
    put_word(16'h0000, 8'h77);
    put_word(16'hFFFF, 8'h77);
    for (int i = 0; i < 2; i++) put_word(16'h8001 + i[15:0], 8'h77);
    put_word(16'h0000, 8'hFF);
    for (int i = 0; i < 3; i++) exp[i] = {32'h0001_2340 + i, 16'hF00D + i[15:0]};
    for (int i = 0; i < 2; i++) exp[3+i] = {32'h0000_FFFF + i, 16'h8001 + i[15:0]};
    drain();
    chk(wr_log.size(), 5, "write count");
    for (int i = 0; i < 5 && i < wr_log.size(); i++) chk(wr_log[i], exp[i], "ram write");
    chk(entry_point, 32'h00BB_CCDD, "entry point");
    chk(done_len, 1, "done pulse length");
    chk(load_abort, 0, "no abort");
  endtask

  task automatic t_abort();
    host.gap = 1;
    do_reset();
    put_word(16'h08AB, 8'h00);
    for (int i = 0; i < 3; i++) put_word(16'h1234, 8'h00);
    // nothing further can happen; observe a fixed window
    repeat (150) @(negedge sys_clk);
    chk(load_abort, 1, "abort on bad key");
    chk({done_len, wr_log.size()}, 0, "no done or write");
    chk(host.q.size(), 2, "fifo takes four then stalls");
    chk(dev_hs, 1, "stalled handshake");
  endtask

  initial
  begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    done_len = 0;
    t_stream(pbbl_pkg::KEY_8BIT, 1);
    t_stream(pbbl_pkg::KEY_16BIT, 6);
    t_abort();
    conclude();
  end
endmodule

`default_nettype wire
